/* common/pcsia_pkg.sv */
package pcsia_pkg;

	// variant codes: 0 unbanked, 1 four banks, 2 eight banks
	localparam int VARIANT_SMALL = 0;
	localparam int VARIANT_FOUR  = 1;
	localparam int VARIANT_EIGHT = 2;

	localparam int PC_MAX_W = 11;

	// register file locations, mirrored in every bank
	localparam logic [4:0] ADDR_INDIRECT = 5'h00;
	localparam logic [4:0] ADDR_PC_LOW   = 5'h02;
	localparam logic [4:0] ADDR_STATUS   = 5'h03;
	localparam logic [4:0] ADDR_POINTER  = 5'h04;

	localparam int STATUS_PAGE_LSB = 5;

	localparam logic [10:0] PC_MASK_SMALL  = 11'h1ff;
	localparam logic [10:0] PC_MASK_LARGE  = 11'h7ff;
	localparam logic [10:0] RST_VEC_SMALL  = 11'h1ff;
	localparam logic [10:0] RST_VEC_LARGE  = 11'h7ff;
	localparam logic [1:0]  RST_PAGE       = 2'h0;
	localparam logic [7:0]  RST_POINTER    = 8'h00;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_JUMP = 3'h1,
		OP_CALL = 3'h2,
		OP_RETL = 3'h3
	} pcsia_op_t;

	typedef struct packed {
		pcsia_op_t   op;
		logic [8:0]  lit;
	} pcsia_instr_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} pcsia_bus_t;

	typedef struct packed {
		logic [10:0] pc;
		logic [10:0] stk1;
		logic [10:0] stk2;
		logic [1:0]  page;
		logic [7:0]  ptr;
		logic [7:0]  rdData;
		logic        wLoad;
		logic [7:0]  wValue;
	} pcsia_state_t;

endpackage

/* rtl/pcsia_core.sv */
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module pcsia_core
#(
	parameter int VARIANT = 0
)
(
	input  wire logic                   clk_sys,
	input  wire logic                   rst_n,
	input  wire pcsia_pkg::pcsia_instr_t instr,
	input  wire pcsia_pkg::pcsia_bus_t   bus,
	output logic [7:0]                  rdData,
	output pcsia_pkg::pcsia_bus_t        fileBus,
	input  wire logic [7:0]             fileRdData,
	output logic [10:0]                 pc,
	output logic [10:0]                 stackTop,
	output logic [7:0]                  pointerView,
	output logic                        wLoad,
	output logic [7:0]                  wValue
);
	import pcsia_pkg::*;

	// the variant fixes widths at elaboration
	localparam logic [10:0] PC_MASK = (VARIANT == VARIANT_SMALL) ? PC_MASK_SMALL : PC_MASK_LARGE;
	localparam logic [10:0] RST_VEC = (VARIANT == VARIANT_SMALL) ? RST_VEC_SMALL : RST_VEC_LARGE;

	pcsia_state_t s_q;
	pcsia_state_t s_d;

	logic        isInd;
	logic        nullInd;
	logic [2:0]  bankSel;
	logic [7:0]  effAddr;
	logic        ownHit;
	logic [7:0]  ownData;
	logic [1:0]  pageBits;
	logic [10:0] pcInc;
	logic        pcLowWr;

	// unimplemented pointer bits read as ones
	always_comb
	begin
		case (VARIANT)
			VARIANT_SMALL: pointerView = {3'h7, s_q.ptr[4:0]};
			VARIANT_FOUR:  pointerView = {1'b1, s_q.ptr[6:0]};
			default:       pointerView = s_q.ptr;
		endcase
	end

	always_comb
	begin
		case (VARIANT)
			VARIANT_SMALL: bankSel = 3'h0;
			VARIANT_FOUR:  bankSel = {1'b0, s_q.ptr[6:5]};
			default:       bankSel = s_q.ptr[7:5];
		endcase
	end

	// small part has no paging; its page field is only storage
	assign pageBits = (VARIANT == VARIANT_SMALL) ? 2'h0 : s_q.page;
	assign pcInc    = (s_q.pc + 11'h001) & PC_MASK;
	assign isInd    = (bus.addr[4:0] == ADDR_INDIRECT);
	assign nullInd  = isInd && (s_q.ptr[4:0] == ADDR_INDIRECT);
	assign effAddr  = isInd ? {bankSel, s_q.ptr[4:0]} : bus.addr;

	// own registers decode after redirection, so indirect hits them too
	always_comb
	begin
		ownHit  = 1'b1;
		ownData = 8'h00;
		case (effAddr[4:0])
			ADDR_PC_LOW:  ownData = s_q.pc[7:0];
			ADDR_STATUS:  ownData = {1'b0, s_q.page, 5'h00};
			ADDR_POINTER: ownData = pointerView;
			default:      ownHit  = 1'b0;
		endcase
		if (nullInd)
		begin
			ownHit = 1'b1;
		end
	end

	assign pcLowWr = bus.wr && !nullInd && (effAddr[4:0] == ADDR_PC_LOW);

	// everything else goes to the register file; the port itself never does
	always_comb
	begin
		fileBus.addr  = effAddr;
		fileBus.wdata = bus.wdata;
		fileBus.wr    = bus.wr && !ownHit;
		fileBus.rd    = bus.rd && !ownHit;
	end

	always_comb
	begin
		s_d        = s_q;
		s_d.wLoad  = 1'b0;
		s_d.rdData = 8'h00;
		s_d.pc     = pcInc;
		if (bus.rd)
		begin
			s_d.rdData = ownHit ? ownData : fileRdData;
		end
		if (bus.wr && !nullInd && effAddr[4:0] == ADDR_STATUS)
		begin
			s_d.page = bus.wdata[STATUS_PAGE_LSB +: 2];
		end
		if (bus.wr && !nullInd && effAddr[4:0] == ADDR_POINTER)
		begin
			s_d.ptr = bus.wdata;
		end
		// a computed jump loses to a branch in the same cycle
		if (pcLowWr)
		begin
			s_d.pc = {pageBits, 1'b0, bus.wdata} & PC_MASK;
		end
		case (instr.op)
			OP_JUMP:
			begin
				s_d.pc = {pageBits, instr.lit} & PC_MASK;
			end
			OP_CALL:
			begin
				s_d.stk2 = s_q.stk1;
				s_d.stk1 = pcInc;
				s_d.pc   = {pageBits, 1'b0, instr.lit[7:0]} & PC_MASK;
			end
			OP_RETL:
			begin
				s_d.pc     = s_q.stk1;
				s_d.stk1   = s_q.stk2;
				s_d.wLoad  = 1'b1;
				s_d.wValue = instr.lit[7:0];
			end
			default:
			begin
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q        <= '0;
			s_q.pc     <= RST_VEC;
			s_q.page   <= RST_PAGE;
			s_q.ptr    <= RST_POINTER;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign rdData   = s_q.rdData;
	assign pc       = s_q.pc;
	assign stackTop = s_q.stk1;
	assign wLoad    = s_q.wLoad;
	assign wValue   = s_q.wValue;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	property p_pc_inc;
		(instr.op == OP_NONE && !pcLowWr) |=> (pc == (($past(pc) + 11'h001) & PC_MASK));
	endproperty
	a_pc_inc: assert property (p_pc_inc) else $error("counter did not advance by one");

	property p_jump;
		(instr.op == OP_JUMP) |=> (pc[8:0] == $past(instr.lit));
	endproperty
	a_jump: assert property (p_jump) else $error("jump target low bits wrong");

	property p_pc_low_read;
		(bus.rd && !isInd && bus.addr[4:0] == ADDR_PC_LOW) |=> (rdData == $past(pc[7:0]));
	endproperty
	a_pc_low_read: assert property (p_pc_low_read) else $error("counter low byte read wrong");

	property p_page_load;
		(VARIANT != VARIANT_SMALL && instr.op != OP_NONE && instr.op != OP_RETL)
			|=> (pc[10:9] == $past(s_q.page));
	endproperty
	a_page_load: assert property (p_page_load) else $error("page bits not placed in counter");

	property p_call_bit8;
		(instr.op == OP_CALL) |=> (!pc[8] && pc[7:0] == $past(instr.lit[7:0]));
	endproperty
	a_call_bit8: assert property (p_call_bit8) else $error("call did not clear bit 8");

	property p_page_hold;
		(!bus.wr) |=> $stable(s_q.page);
	endproperty
	a_page_hold: assert property (p_page_hold) else $error("page bits moved without a write");

	property p_reset_vec;
		@(posedge clk_sys) disable iff (1'b0) !rst_n |-> (pc == RST_VEC);
	endproperty
	a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong");

	property p_reset_page;
		@(posedge clk_sys) disable iff (1'b0) !rst_n |-> (s_q.page == RST_PAGE);
	endproperty
	a_reset_page: assert property (p_reset_page) else $error("page bits not cleared by reset");

	property p_call_stack;
		(instr.op == OP_CALL) |=>
			(s_q.stk2 == $past(s_q.stk1)) && (stackTop == (($past(pc) + 11'h001) & PC_MASK));
	endproperty
	a_call_stack: assert property (p_call_stack) else $error("call push wrong");

	property p_ret_stack;
		(instr.op == OP_RETL) |=> (pc == $past(s_q.stk1)) && (stackTop == $past(s_q.stk2))
			&& (s_q.stk2 == $past(s_q.stk2));
	endproperty
	a_ret_stack: assert property (p_ret_stack) else $error("return pop wrong");

	property p_ret_w;
		(instr.op == OP_RETL) |=> (wLoad && wValue == $past(instr.lit[7:0]));
	endproperty
	a_ret_w: assert property (p_ret_w) else $error("working register literal not loaded");

	property p_redirect;
		(isInd && !ownHit && (bus.rd || bus.wr)) |->
			(fileBus.addr[4:0] == s_q.ptr[4:0]) && (fileBus.rd == bus.rd);
	endproperty
	a_redirect: assert property (p_redirect) else $error("indirect access not redirected");

	property p_null_read;
		(bus.rd && nullInd) |=> (rdData == 8'h00);
	endproperty
	a_null_read: assert property (p_null_read) else $error("self indirect read not zero");

	property p_null_write;
		(bus.wr && nullInd) |-> !fileBus.wr ##1 ($stable(s_q.ptr) && $stable(s_q.page));
	endproperty
	a_null_write: assert property (p_null_write) else $error("self indirect write stored");

	property p_view;
		(VARIANT == VARIANT_SMALL) |-> (pointerView[7:5] == 3'h7);
	endproperty
	a_view: assert property (p_view) else $error("unbanked pointer upper bits not ones");

	property p_ret_quiet;
		(instr.op != OP_RETL) |=> !wLoad;
	endproperty
	a_ret_quiet: assert property (p_ret_quiet) else $error("working register load without return");

	property p_pc_range;
		((pc & ~PC_MASK) == 11'h000) && ((stackTop & ~PC_MASK) == 11'h000);
	endproperty
	a_pc_range: assert property (p_pc_range) else $error("counter or stack wider than variant");

	property p_pclow_write;
		(pcLowWr && instr.op == OP_NONE) |=> (!pc[8] && pc[7:0] == $past(bus.wdata));
	endproperty
	a_pclow_write: assert property (p_pclow_write) else $error("low byte write load wrong");

	property p_pclow_page;
		(VARIANT != VARIANT_SMALL && pcLowWr && instr.op == OP_NONE)
			|=> (pc[10:9] == $past(s_q.page));
	endproperty
	a_pclow_page: assert property (p_pclow_page) else $error("low byte write lost page");

	property p_stack_idle;
		(instr.op == OP_NONE) |=> ($stable(stackTop) && $stable(s_q.stk2));
	endproperty
	a_stack_idle: assert property (p_stack_idle) else $error("stack moved while idle");

	property p_jump_stack;
		(instr.op == OP_JUMP) |=> ($stable(stackTop) && $stable(s_q.stk2));
	endproperty
	a_jump_stack: assert property (p_jump_stack) else $error("jump disturbed the stack");

	property p_read_zero;
		(!bus.rd) |=> (rdData == 8'h00);
	endproperty
	a_read_zero: assert property (p_read_zero) else $error("read data stood too long");

	property p_file_read;
		(bus.rd && !ownHit) |=> (rdData == $past(fileRdData));
	endproperty
	a_file_read: assert property (p_file_read) else $error("file read data not passed on");

	property p_null_nofile;
		(bus.rd && nullInd) |-> !fileBus.rd;
	endproperty
	a_null_nofile: assert property (p_null_nofile) else $error("self indirect read reached file");

	property p_bank_addr;
		isInd |-> (fileBus.addr[4:0] == s_q.ptr[4:0]);
	endproperty
	a_bank_addr: assert property (p_bank_addr) else $error("indirect low address wrong");

	property p_bank_sel;
		(isInd && VARIANT == VARIANT_EIGHT) |-> (fileBus.addr[7:5] == s_q.ptr[7:5]);
	endproperty
	a_bank_sel: assert property (p_bank_sel) else $error("eight bank select wrong");

	property p_bank_four;
		(isInd && VARIANT == VARIANT_FOUR) |-> (fileBus.addr[7:5] == {1'b0, s_q.ptr[6:5]});
	endproperty
	a_bank_four: assert property (p_bank_four) else $error("four bank select wrong");

	property p_view_four;
		(VARIANT == VARIANT_FOUR) |-> pointerView[7];
	endproperty
	a_view_four: assert property (p_view_four) else $error("four bank pointer bit 7 not one");

	property p_direct;
		(!isInd) |-> (fileBus.addr == bus.addr);
	endproperty
	a_direct: assert property (p_direct) else $error("direct address altered");

	property p_ptr_write;
		(bus.wr && !nullInd && effAddr[4:0] == ADDR_POINTER) |=> (s_q.ptr == $past(bus.wdata));
	endproperty
	a_ptr_write: assert property (p_ptr_write) else $error("pointer write lost");

	property p_status_read;
		(bus.rd && !isInd && bus.addr[4:0] == ADDR_STATUS) |=> (rdData == {1'b0, $past(s_q.page), 5'h00});
	endproperty
	a_status_read: assert property (p_status_read) else $error("page bits read wrong");

endmodule // pcsia_core

/* verif/pcsia_regfile.sv */
`timescale 1ns/1ps
module pcsia_regfile
(
	input  wire pcsia_pkg::pcsia_bus_t fileBus,
	input  wire logic                  clk_sys,
	output logic [7:0]                 fileRdData
);
	import pcsia_pkg::*;
	logic [7:0] mem [256];
	// seeded pattern, so no unwritten cell but 8'h5a passes for zero
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5a;
	end
	always @(posedge clk_sys)
	begin
		if (fileBus.wr)
			mem[fileBus.addr] <= fileBus.wdata;
	end
	assign fileRdData = mem[fileBus.addr];
endmodule // pcsia_regfile

/* verif/test_pcsia_core.sv */
`timescale 1ns/1ps
module test_pcsia_core;
	import pcsia_pkg::*;
	logic         clk_sys = 1'b0;
	logic         rst_n   = 1'b1;
	pcsia_instr_t instr   = '0;
	pcsia_bus_t   bus     = '0;
	pcsia_bus_t   fileBus;
	logic [7:0]   rdData;
	logic [7:0]   fileRdData;
	logic [7:0]   pointerView;
	logic [7:0]   wValue;
	logic [10:0]  pc;
	logic [10:0]  stackTop;
	logic         wLoad;
	int           fail_count = 0;
	int           num_checks = 0;
	// op, literal, expected pc, expected stack top; page bits still 0
	logic [33:0]  rows [8] = '{
		{3'h1, 9'h1ff, 11'h1ff, 11'h000}, {3'h0, 9'h000, 11'h200, 11'h000},
		{3'h2, 9'h012, 11'h012, 11'h201}, {3'h2, 9'h034, 11'h034, 11'h013},
		{3'h2, 9'h056, 11'h056, 11'h035}, {3'h3, 9'h000, 11'h035, 11'h013},
		{3'h3, 9'h000, 11'h013, 11'h013}, {3'h3, 9'h000, 11'h013, 11'h013}};

	always #10 clk_sys = ~clk_sys;

	pcsia_core #(.VARIANT(VARIANT_EIGHT)) i_pcsia_core (.clk_sys(clk_sys), .rst_n(rst_n),
		.instr(instr), .bus(bus), .rdData(rdData), .fileBus(fileBus),
		.fileRdData(fileRdData), .pc(pc), .stackTop(stackTop),
		.pointerView(pointerView), .wLoad(wLoad), .wValue(wValue));
	pcsia_regfile i_pcsia_regfile (.fileBus(fileBus), .clk_sys(clk_sys),
		.fileRdData(fileRdData));

	// results of an edge are looked at once they have settled
	task automatic cyc();
		@(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
		num_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus <= '0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus <= '0;
		#1;
		chk("rdData", 11'(e), 11'(rdData));
	endtask
	task automatic ex(input pcsia_op_t o, input logic [8:0] l, input logic [10:0] e);
		instr <= '{op: o, lit: l};
		@(posedge clk_sys);
		instr <= '0;
		#1;
		chk("pc", e, pc);
	endtask
	task automatic rstchk();
		rst_n <= 1'b0;
		repeat (5) cyc();
		chk("pc", 11'h7ff, pc);
		chk("stackTop", 11'h000, stackTop);
		chk("pointerView", 11'h000, 11'(pointerView));
		rst_n <= 1'b1;
		rd(8'h03, 8'h00);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		rstchk();
		for (int i = 0; i < 8; i++)
		begin
			instr <= {rows[i][33:31], rows[i][30:22]};
			cyc();
			chk("pc", rows[i][21:11], pc);
			chk("stackTop", rows[i][10:0], stackTop);
		end
		instr <= '0;
		wr(8'h03, 8'h60);
		ex(OP_JUMP, 9'h0aa, 11'h6aa);
		ex(OP_CALL, 9'h1ff, 11'h6ff);
		chk("stackTop", 11'h6ab, stackTop);
		wr(8'h02, 8'h40);
		chk("pc", 11'h640, pc);
		rd(8'h02, 8'h40);
		ex(OP_RETL, 9'h055, 11'h6ab);
		chk("wLoad", 11'h001, 11'(wLoad));
		chk("wValue", 11'h055, 11'(wValue));
		cyc();
		chk("wLoad", 11'h000, 11'(wLoad));
		wr(8'h04, 8'he9);
		chk("pointerView", 11'h0e9, 11'(pointerView));
		wr(8'h00, 8'h10);
		rd(8'h00, 8'h10);
		rd(8'he9, 8'h10);
		wr(8'h04, 8'h00);
		bus <= '{addr: 8'h00, wdata: 8'hee, wr: 1'b1, rd: 1'b0};
		#1;
		chk("fileBus.wr", 11'h000, 11'(fileBus.wr));
		@(posedge clk_sys);
		bus <= '0;
		#1;
		rd(8'h00, 8'h00);
		rstchk();
		close_out();
	end
endmodule // test_pcsia_core
